// *** design/lhw_regs.vh ***
// register map, field positions and reset values of the lan host wake block
// assumes a 32-bit ahb-lite slave with word-aligned registers
`ifndef LHW_REGS_VH
`define LHW_REGS_VH

`define LHW_ADDR_W 4
`define LHW_WUC_OFF 4'h0
`define LHW_WUS_OFF 4'h4
`define LHW_PMC_OFF 4'h8
`define LHW_STAT_OFF 4'hc

// wakeup_control_reg fields
`define LHW_WUC_PATTERN_WAKE_ENABLE 0
`define LHW_WUC_SRC 1
`define LHW_WUC_LINK_CHANGE_WAKE_ENABLE 2
`define LHW_WUC_LINK_CHANGE_OVERRIDE 3
`define LHW_WUC_LPS 4
`define LHW_WUC_W 5
// wake_status_reg fields
`define LHW_WUS_PAT 0
`define LHW_WUS_LNK 1
`define LHW_WUS_W 2
// power_state_ctrl_reg fields
`define LHW_PMC_D0 1:0
`define LHW_PMC_EN 8
`define LHW_PMC_ST 15
`define LHW_D3 2'h3
`define LHW_WUC_RST 5'h00

`endif

// *** design/lhw_pme_msg.v ***
// one-shot in-band power event message sender
// assumes the link side takes msg_valid whenever msg_ready is high
`timescale 1ns/1ps
`default_nettype none
module lhw_pme_msg (
  input wire hclk, // clock
  input wire hresetn, // async reset, low
  input wire req, // one-cycle request
  input wire msg_ready, // link accepts message
  output wire msg_valid // message pending
);
  reg pend_reg;
  wire pend_next;
  // a new request wins over the handshake completing
  assign pend_next = req | (pend_reg & ~msg_ready);
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pend_reg <= 1'b0;
    else
      pend_reg <= pend_next;
  end
  assign msg_valid = pend_reg;
endmodule
`default_nettype wire

// *** design/lhw_wake_ctrl.v ***
// wake control: wake source select, host and engine wake sequences,
// pattern and link-change wake, ahb-lite register slave
// assumes nvm load strobes and event pulses are on hclk; lanes are pins
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lhw_regs.vh"
module lhw_wake_ctrl (
  input wire hclk, // 100 mhz clock
  input wire hresetn, // async reset, low
  input wire hsel, // slave select
  input wire [31:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write
  input wire [2:0] hsize, // size, word only
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready
  output wire hreadyout, // slave ready
  output wire hresp, // always okay
  output reg [31:0] hrdata, // read data
  input wire nvm_load, // one-cycle nvm reload strobe
  input wire nvm_src_sel, // stored wake source select
  input wire nvm_pattern_wake_enable, // pattern wake enable, init word 2
  input wire pkt_valid, // one-cycle: packet received
  input wire pkt_pattern_match, // packet is a wake pattern
  input wire mac_engine_event, // one-cycle: mac engine wake match
  input wire link_status_change, // one-cycle: link went up or down
  input wire inband_host_wake, // one-cycle: phy in-band host wake
  input wire inband_engine_wake, // one-cycle: phy in-band engine wake
  input wire lan_connect_link_up, // link active (hclk domain)
  input wire [1:0] phy_receive_lanes, // pin lanes, wake when link down
  input wire engine_off_state, // embedded controller is off
  input wire pme_msg_ready, // link takes power event message
  output wire pme_msg_valid, // in-band power event message
  output reg host_wake_out, // system wake
  output reg engine_wake_out, // embedded controller wake
  output reg mac_power_down, // request mac power down
  output reg pkt_discard // drop the triggering packet
);
  localparam ST_RUN = 2'h0;
  localparam ST_ARM = 2'h1;
  localparam ST_OFF = 2'h2;

  reg [`LHW_WUC_W-1:0] wuc_reg;
  reg [`LHW_WUS_W-1:0] wus_reg;
  reg [1:0] dstate_reg;
  reg pme_en_reg;
  reg power_event_status_reg;
  reg [1:0] st_reg;
  reg [1:0] st_next;
  reg [1:0] lane_s1_reg;
  reg [1:0] lane_s2_reg;
  reg lane_prev_reg;
  reg dph_wr_reg;
  reg dph_rd_reg;
  reg [`LHW_ADDR_W-1:0] dph_addr_reg;

  wire addr_ph;
  wire wr_wuc;
  wire wr_wus;
  wire wr_pmc;
  wire wake_source_select;
  wire pattern_wake_enable;
  wire link_change_wake_enable;
  wire link_change_override;
  wire lnk_allowed;
  wire lane_wake;
  wire lane_any;
  wire pat_hit;
  wire lnk_hit;
  wire host_ev;
  wire eng_ev;
  wire pme_clr;
  wire wus_pat_clr;
  wire wus_lnk_clr;
  wire addr_ok;
  wire eng_off_fall;
  reg eng_off_prev_reg;

  assign wake_source_select = wuc_reg[`LHW_WUC_SRC];
  assign pattern_wake_enable = wuc_reg[`LHW_WUC_PATTERN_WAKE_ENABLE];
  assign link_change_wake_enable = wuc_reg[`LHW_WUC_LINK_CHANGE_WAKE_ENABLE];
  assign link_change_override = wuc_reg[`LHW_WUC_LINK_CHANGE_OVERRIDE];

  // ahb-lite: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ph = hsel & hready & htrans[1];
  // upper address bits must be clear, so no register aliases elsewhere
  assign addr_ok = ~|haddr[31:`LHW_ADDR_W];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_reg <= 1'b0;
      dph_rd_reg <= 1'b0;
      dph_addr_reg <= {`LHW_ADDR_W{1'b0}};
    end
    else if (hready)
    begin
      dph_wr_reg <= addr_ph & addr_ok & hwrite;
      dph_rd_reg <= addr_ph & addr_ok & ~hwrite;
      dph_addr_reg <= haddr[`LHW_ADDR_W-1:0];
    end
  end

  assign wr_wuc = dph_wr_reg & (dph_addr_reg == `LHW_WUC_OFF);
  assign wr_wus = dph_wr_reg & (dph_addr_reg == `LHW_WUS_OFF);
  assign wr_pmc = dph_wr_reg & (dph_addr_reg == `LHW_PMC_OFF);

  // lanes come from pins: two flops before use
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lane_s1_reg <= 2'h0;
      lane_s2_reg <= 2'h0;
      lane_prev_reg <= 1'b0;
    end
    else
    begin
      lane_s1_reg <= phy_receive_lanes;
      lane_s2_reg <= lane_s1_reg;
      lane_prev_reg <= lane_any;
    end
  end
  assign lane_any = |lane_s2_reg;
  // lanes only mean wake while the link is down
  assign lane_wake = lane_any & ~lane_prev_reg & ~lan_connect_link_up;

  // pattern hits are ignored until software clears the received bit
  assign pat_hit = pattern_wake_enable & pkt_valid & pkt_pattern_match
    & ~wus_reg[`LHW_WUS_PAT];
  assign lnk_allowed = ~link_change_override |
    (pattern_wake_enable & link_change_wake_enable);
  assign lnk_hit = link_status_change & lnk_allowed
    & ~wus_reg[`LHW_WUS_LNK];

  // host events; phy-side ones only count when the phy owns wake
  assign host_ev = pat_hit | lnk_hit | (mac_engine_event & ~wake_source_select)
    | (wake_source_select & (inband_host_wake | lane_wake));
  assign eng_ev = wake_source_select & inband_engine_wake;

  // write 1 clears status; set wins over clear
  assign pme_clr = wr_pmc & hwdata[`LHW_PMC_ST];
  assign wus_pat_clr = wr_wus & hwdata[`LHW_WUS_PAT];
  assign wus_lnk_clr = wr_wus & hwdata[`LHW_WUS_LNK];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wuc_reg <= `LHW_WUC_RST;
      wus_reg <= {`LHW_WUS_W{1'b0}};
      dstate_reg <= 2'h0;
      pme_en_reg <= 1'b0;
      power_event_status_reg <= 1'b0;
    end
    else
    begin
      if (wr_wuc)
        wuc_reg <= hwdata[`LHW_WUC_W-1:0];
      else if (nvm_load)
      begin
        wuc_reg[`LHW_WUC_SRC] <= nvm_src_sel;
        wuc_reg[`LHW_WUC_PATTERN_WAKE_ENABLE] <= nvm_pattern_wake_enable;
      end
      if (wr_pmc)
      begin
        dstate_reg <= hwdata[`LHW_PMC_D0];
        pme_en_reg <= hwdata[`LHW_PMC_EN];
      end
      if (host_ev)
        power_event_status_reg <= 1'b1;
      else if (pme_clr)
        power_event_status_reg <= 1'b0;
      if (pat_hit)
        wus_reg[`LHW_WUS_PAT] <= 1'b1;
      else if (wus_pat_clr)
        wus_reg[`LHW_WUS_PAT] <= 1'b0;
      if (lnk_hit)
        wus_reg[`LHW_WUS_LNK] <= 1'b1;
      else if (wus_lnk_clr || !lnk_allowed)
        wus_reg[`LHW_WUS_LNK] <= 1'b0;
    end
  end

  // power sequencing for phy-armed sleep
  always @*
  begin
    st_next = st_reg;
    case (st_reg)
      ST_RUN:
        if (dstate_reg == `LHW_D3 && wake_source_select)
          st_next = ST_ARM;
      ST_ARM:
        if (host_ev || eng_ev || dstate_reg != `LHW_D3)
          st_next = ST_RUN;
        else if (engine_off_state && !lan_connect_link_up)
          st_next = ST_OFF;
      ST_OFF:
        if (lane_wake || host_ev || eng_ev)
          st_next = ST_RUN;
      default:
        st_next = ST_RUN;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= ST_RUN;
      host_wake_out <= 1'b0;
      engine_wake_out <= 1'b0;
      mac_power_down <= 1'b0;
      pkt_discard <= 1'b0;
      eng_off_prev_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      eng_off_prev_reg <= engine_off_state;
      mac_power_down <= (st_next == ST_OFF);
      // wake holds until status cleared or enable dropped
      host_wake_out <= pme_en_reg & (power_event_status_reg | host_ev)
        & ~(wr_pmc & ~hwdata[`LHW_PMC_EN])
        & ~(pme_clr & ~host_ev);
      if (eng_ev)
        engine_wake_out <= 1'b1;
      else if (eng_off_fall)
        engine_wake_out <= 1'b0;
      // no packet that triggered a wake reaches the host
      pkt_discard <= pat_hit | mac_engine_event;
    end
  end

  // engine wake is released when the engine leaves its off state
  assign eng_off_fall = eng_off_prev_reg & ~engine_off_state;

  // pattern and link wakes also go out in-band
  lhw_pme_msg u_pme (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(pat_hit | lnk_hit),
    .msg_ready(pme_msg_ready),
    .msg_valid(pme_msg_valid)
  );

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ph && !hwrite)
    begin
      hrdata <= 32'h0000_0000;
      // unmapped addresses read zero
      if (addr_ok)
      begin
        case (haddr[`LHW_ADDR_W-1:0])
          `LHW_WUC_OFF: hrdata[`LHW_WUC_W-1:0] <= wuc_reg;
          `LHW_WUS_OFF:
          begin
            hrdata[`LHW_WUS_PAT] <= wus_reg[`LHW_WUS_PAT];
            hrdata[`LHW_WUS_LNK] <= wus_reg[`LHW_WUS_LNK]
              & lnk_allowed;
          end
          `LHW_PMC_OFF:
          begin
            hrdata[`LHW_PMC_D0] <= dstate_reg;
            hrdata[`LHW_PMC_EN] <= pme_en_reg;
            hrdata[`LHW_PMC_ST] <= power_event_status_reg;
          end
          `LHW_STAT_OFF:
          begin
            hrdata[1:0] <= st_reg;
            hrdata[2] <= host_wake_out;
            hrdata[3] <= engine_wake_out;
          end
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/lhw_phy_model.sv ***
// far side: wake_source_select signalling and power event message sink
// assumes the bench pulses wake for one hclk cycle
`timescale 1ns/1ps
`default_nettype none
module lhw_phy_model (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic wake, // wake seen
  input wire logic host, // host or engine
  input wire logic link_up, // link active
  input wire logic slow, // stall messages
  input wire logic msg_valid, // message offered
  output logic msg_ready, // message taken
  output logic ib_host, // in-band host
  output logic ib_eng, // in-band engine
  output logic [1:0] lanes // lane wake
);
  logic [1:0] wait_reg;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      {ib_host, ib_eng, lanes, wait_reg} <= '0;
    end
    else
    begin
      ib_host <= wake && link_up && host;
      ib_eng <= wake && link_up && !host;
      lanes <= {2{wake && !link_up}};
      wait_reg <= msg_valid ? wait_reg + 2'h1 : 2'h0;
    end
  // slow mode takes the message only on its fourth cycle
  assign msg_ready = msg_valid && (!slow || wait_reg == 2'h3);
endmodule
`default_nettype wire

// *** bench/lhw_wake_assertions.sv ***
// checker: wake and message outputs against their causes
// bound into lhw_wake_ctrl; hsel held high by the bench
`timescale 1ns/1ps
`default_nettype none
module lhw_wake_assertions (
  input wire logic hclk, // clk
  input wire logic hresetn, // rst
  input wire logic [31:0] haddr, // adr
  input wire logic [1:0] htrans, // trn
  input wire logic hwrite, // wr
  input wire logic [31:0] hwdata, // wd
  input wire logic hreadyout, // rdy
  input wire logic hresp, // rsp
  input wire logic pkt_valid, // pkt
  input wire logic pkt_pattern_match, // hit
  input wire logic mac_engine_event, // ev
  input wire logic link_status_change, // ev
  input wire logic inband_host_wake, // ev
  input wire logic inband_engine_wake, // ev
  input wire logic [1:0] phy_receive_lanes, // pin
  input wire logic engine_off_state, // lvl
  input wire logic pme_msg_ready, // rdy
  input wire logic pme_msg_valid, // msg
  input wire logic host_wake_out, // out
  input wire logic engine_wake_out // out
);
  default clocking dck @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic pmc_reg, clr_reg;
  logic [2:0] ac_reg, mc_reg;
  // causes stay visible a while: lane wake crosses a synchroniser
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      {pmc_reg, clr_reg, ac_reg, mc_reg} <= '0;
    end
    else
    begin
      pmc_reg <= htrans[1] && hwrite && haddr[3:0] == 4'h8;
      clr_reg <= pmc_reg;
      ac_reg <= (pmc_reg || pkt_valid || mac_engine_event ||
        link_status_change || inband_host_wake || inband_engine_wake ||
        |phy_receive_lanes) ? 3'h6 : ac_reg - {2'h0, |ac_reg};
      mc_reg <= (pkt_valid && pkt_pattern_match || link_status_change) ?
        3'h6 : mc_reg - {2'h0, |mc_reg};
    end
  sequence s_clear;
    pmc_reg && (hwdata[15] || !hwdata[8]);
  endsequence
  sequence s_quiet;
    host_wake_out && !pmc_reg && !clr_reg;
  endsequence
  a_bus_okay: assert property (htrans[1] |-> hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_wake_hold: assert property (
    s_quiet |=> host_wake_out) else $error("wake dropped early");
  a_wake_drop: assert property (
    s_clear |-> ##[1:2] !host_wake_out) else $error("wake stuck");
  a_wake_cause: assert property (
    $rose(host_wake_out) |-> ac_reg != 3'h0) else $error("stray wake");
  a_eng_cause: assert property (
    $rose(engine_wake_out) |-> ac_reg != 3'h0) else $error("stray wake");
  a_eng_drop: assert property (
    $fell(engine_off_state) && !inband_engine_wake |-> ##[1:2]
    !engine_wake_out) else $error("engine wake stuck");
  a_msg_hold: assert property (
    pme_msg_valid && !pme_msg_ready |=> pme_msg_valid)
    else $error("message withdrawn");
  a_msg_cause: assert property (
    $rose(pme_msg_valid) |-> mc_reg != 3'h0) else $error("stray message");
endmodule
bind lhw_wake_ctrl lhw_wake_assertions chk_u (.*);
`default_nettype wire

// *** bench/tb.sv ***
// testbench: register traffic and wake events against lhw_wake_ctrl
// assumes zero-wait slave; hsel and hsize fixed
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h1, hwrite = 1'h0;
  logic [31:0] haddr = '0, hwdata = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic nvm_load = '0, nvm_src_sel = '0, nvm_pattern_wake_enable = '0, slow = '0;
  logic pkt_valid = '0, pkt_pattern_match = '0, mac_engine_event = '0;
  logic link_status_change = '0, lan_connect_link_up = '0;
  logic engine_off_state = '0, pwake = '0, host = '0;
  wire logic hready, hreadyout, hresp, pme_msg_ready, pme_msg_valid;
  wire logic inband_host_wake, inband_engine_wake, host_wake_out;
  wire logic engine_wake_out, mac_power_down, pkt_discard;
  wire logic [1:0] phy_receive_lanes;
  wire logic [31:0] hrdata;
  int n_fail = 0;
  int n_tests = 0;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  lhw_wake_ctrl dut_u (.*);
  lhw_phy_model far_u (.hclk(hclk), .hresetn(hresetn), .wake(pwake),
    .host(host), .link_up(lan_connect_link_up), .slow(slow),
    .msg_valid(pme_msg_valid), .msg_ready(pme_msg_ready),
    .ib_host(inband_host_wake), .ib_eng(inband_engine_wake),
    .lanes(phy_receive_lanes));
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus phase: waits for hready, gives up after 21 cycles
  task step;
    int i;
    i = 0;
    @(posedge hclk);
    while (hready !== 1'h1)
    begin
      @(posedge hclk);
      i++;
      if (i > 20)
      begin
        n_fail++;
        finish_test();
      end
    end
  endtask
  task bus(input logic w, input logic [31:0] a, d, exp);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    step();
    htrans <= '0;
    hwdata <= d;
    step();
    if (!w)
      chk(hrdata, exp);
  endtask
  task run(input logic [4:0] w, input logic [6:0] m, input logic h, g,
    input logic [31:0] s, c);
    bus(1'h1, 32'h0, {27'h0, w}, '0);
    bus(1'h1, 32'h8, 32'h103, '0);
    {lan_connect_link_up, host, pwake, link_status_change,
      mac_engine_event, pkt_pattern_match, pkt_valid} <= m;
    slow <= ~slow;
    @(posedge hclk);
    {pwake, link_status_change, mac_engine_event, pkt_pattern_match,
      pkt_valid} <= '0;
    #1;
    chk(pkt_discard, m[0] & m[1] & w[0] | m[2]);
    repeat (6) @(posedge hclk);
    chk(host_wake_out, h);
    chk(engine_wake_out, g);
    bus(1'h0, 32'h4, '0, s);
    bus(1'h1, 32'h8, c, '0);
    repeat (2) @(posedge hclk);
    chk(host_wake_out, '0);
    bus(1'h1, 32'h8, 32'h8000, '0);
    bus(1'h1, 32'h4, 32'h3, '0);
    engine_off_state <= 1'h1;
    @(posedge hclk);
    engine_off_state <= '0;
    repeat (3) @(posedge hclk);
    chk(engine_wake_out, '0);
  endtask
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h1, 32'h10, '1, '0);
    for (int i = 0; i < 5; i++)
      bus(1'h0, 32'(4 * i), '0, '0);
    {nvm_src_sel, nvm_pattern_wake_enable, nvm_load} <= 3'h7;
    @(posedge hclk);
    nvm_load <= '0;
    bus(1'h0, 32'h0, '0, 32'h3);
    bus(1'h1, 32'h0, 32'h1, '0);
    bus(1'h0, 32'h0, '0, 32'h1);
    run(5'h01, 7'h43, 1'h1, '0, 32'h1, 32'h8103);
    run(5'h00, 7'h43, '0, '0, 32'h0, 32'h8103);
    run(5'h01, 7'h41, '0, '0, 32'h0, 32'h8103);
    run(5'h00, 7'h44, 1'h1, '0, 32'h0, 32'h0003);
    run(5'h0d, 7'h48, 1'h1, '0, 32'h2, 32'h8103);
    run(5'h09, 7'h48, '0, '0, 32'h0, 32'h8103);
    run(5'h0c, 7'h48, '0, '0, 32'h0, 32'h8103);
    run(5'h02, 7'h70, 1'h1, '0, 32'h0, 32'h8103);
    run(5'h02, 7'h50, '0, 1'h1, 32'h0, 32'h8103);
    run(5'h02, 7'h30, 1'h1, '0, 32'h0, 32'h8103);
    bus(1'h1, 32'h0, 32'h2, '0);
    bus(1'h1, 32'h8, 32'h3, '0);
    engine_off_state <= 1'h1;
    repeat (4) @(posedge hclk);
    chk(mac_power_down, 1'h1);
    {pwake, engine_off_state} <= 2'h2;
    @(posedge hclk);
    pwake <= '0;
    repeat (6) @(posedge hclk);
    chk(mac_power_down, '0);
    finish_test();
  end
endmodule
`default_nettype wire
